// *** core/bmac_ctrl.sv ***
// Beacon mode selection, flash supervision, alarms, lamps and APB registers
//
// Behaviour
// RULE_01 - Day lamp in day, night lamp in night
// RULE_02 - Markers on only at night when installed
// RULE_03 - Sync lamp flicks every six seconds
// RULE_04 - Flash_lamp_a lamp toggles on each valid flash
// RULE_05 - Photocell alarm when photocell never changes state
// RULE_06 - Red alarm after three missed night flashes
// RULE_07 - Night error while night flashes go unconfirmed
// RULE_08 - Marker alarm follows marker sense failure
// RULE_09 - Trigger lamp follows trigger voltage present
// RULE_10 - Strobe never fires in day mode
// RULE_11 - Night flashes use low intensity
// RULE_12 - Forced switch position starts eight-hour timer
// RULE_13 - Eight hours forced returns to automatic
// RULE_14 - Master sends mode and sync to slaves
// RULE_15 - Photocell ignored up to one minute after power-up
// RULE_16 - Slaves follow master, day when disconnected
// RULE_17 - Missed count clears on flash, night entry
// RULE_18 - Timer restarts on forced change, clears on auto
`timescale 1ns/1ps

module bmac_ctrl
  import bmac_pkg::*;
#(
  parameter int unsigned TICK_LEN = TICK_CYCLES,
  parameter int unsigned OVERRIDE_LEN_S = OVERRIDE_S,
  parameter int unsigned PHOTOCELL_ALARM_LAMP_LEN_S = PHOTOCELL_ALARM_LAMP_S,
  parameter int unsigned SYNC_PULSE_LEN = SYNC_PULSE_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] intensity_select_switch,
  input wire logic photocell_dark,
  input wire logic flash_detect,
  input wire logic marker_sense_fail,
  input wire logic trigger_voltage_present,
  output logic strobe_fire,
  output logic strobe_low_intensity,
  output logic marker_relay,
  output logic day_mode_lamp,
  output logic night_mode_lamp,
  output logic marker_on_lamp,
  output logic sync_lamp,
  output logic flash_lamp_a,
  output logic photocell_alarm_lamp,
  output logic red_alarm_lamp,
  output logic night_intensity_error_lamp,
  output logic marker_failure_lamp,
  output logic trigger_supply_lamp,
  output logic interconnect_sync_line,
  output logic interconnect_mode_line,
  output logic irq
);

  function automatic logic sw_forced(input logic [1:0] sw);
    return (sw == SW_DAY) || (sw == SW_NIGHT);
  endfunction

  bmac_mode_t mode_reg;
  bmac_alarm_t alarm_reg, alarm_prev_reg;
  logic [1:0] ctrl_reg, sw_prev_reg, flash_sec_reg, miss_reg;
  logic [INT_WIDTH-1:0] int_stat_reg, int_mask_reg, int_events;
  logic [31:0] tick_cnt_reg, sync_pulse_reg, ovr_sec_reg, pec_sec_reg;
  logic [2:0] sync_sec_reg;
  logic [5:0] startup_sec_reg;
  logic pec_ready_reg, ovr_done_reg, pec_prev_reg, pending_reg, night_prev_reg;
  logic tick, night_next, override_active, flash_slot, sync_slot, fire, apb_access, apb_done;

  assign apb_access = psel && penable;
  assign apb_done = apb_access && pready;

  // One-second tick; every slower timer counts ticks to keep counters small
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_reg <= 32'h0;
    end else if (tick_cnt_reg == TICK_LEN - 1) begin
      tick_cnt_reg <= 32'h0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h1;
    end
  end
  assign tick = (tick_cnt_reg == TICK_LEN - 1);

  // Sync and flash slots run in both modes so slaves stay aligned
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_sec_reg <= 3'h0;
      flash_sec_reg <= 2'h0;
    end else if (tick) begin
      sync_sec_reg <= (sync_sec_reg == 3'(SYNC_PERIOD_S - 1)) ? 3'h0 : sync_sec_reg + 3'h1;
      flash_sec_reg <= (flash_sec_reg == 2'(FLASH_PERIOD_S - 1)) ? 2'h0 : flash_sec_reg + 2'h1;
    end
  end
  assign sync_slot = tick && (sync_sec_reg == 3'(SYNC_PERIOD_S - 1));
  assign flash_slot = tick && (flash_sec_reg == 2'(FLASH_PERIOD_S - 1));
  assign fire = flash_slot && (mode_reg == ST_NIGHT); // RULE_10

  // Brief sync flick, also sent on the interconnect by a master
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_pulse_reg <= 32'h0;
    end else if (sync_slot) begin
      sync_pulse_reg <= SYNC_PULSE_LEN; // RULE_03
    end else if (sync_pulse_reg != 32'h0) begin
      sync_pulse_reg <= sync_pulse_reg - 32'h1;
    end
  end

  // Photocell is not trusted until the startup delay has elapsed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      startup_sec_reg <= 6'h0;
      pec_ready_reg <= 1'b0;
    end else if (tick && !pec_ready_reg) begin
      if (startup_sec_reg == 6'(PEC_STARTUP_S - 1)) begin
        pec_ready_reg <= 1'b1; // RULE_15
      end
      startup_sec_reg <= startup_sec_reg + 6'h1;
    end
  end

  // Override timer; a done timer stays done until the switch moves
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovr_sec_reg <= 32'h0;
      ovr_done_reg <= 1'b0;
      sw_prev_reg <= SW_AUTO;
    end else begin
      sw_prev_reg <= intensity_select_switch;
      if (!sw_forced(intensity_select_switch)) begin
        ovr_sec_reg <= 32'h0; // RULE_18
        ovr_done_reg <= 1'b0;
      end else if (intensity_select_switch != sw_prev_reg) begin
        ovr_sec_reg <= 32'h0; // RULE_12 RULE_18
        ovr_done_reg <= 1'b0;
      end else if (tick && !ovr_done_reg) begin
        if (ovr_sec_reg == OVERRIDE_LEN_S - 1) begin
          ovr_done_reg <= 1'b1; // RULE_13
        end
        ovr_sec_reg <= ovr_sec_reg + 32'h1;
      end
    end
  end

  // A position just entered counts as forced before the timer sees it
  assign override_active = sw_forced(intensity_select_switch) &&
      (!ovr_done_reg || intensity_select_switch != sw_prev_reg);

  always_comb begin
    if (override_active) begin
      night_next = (intensity_select_switch == SW_NIGHT); // RULE_12
    end else begin
      night_next = pec_ready_reg && photocell_dark; // RULE_13 RULE_15
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= ST_DAY;
    end else begin
      unique case (mode_reg)
        ST_DAY: begin
          if (night_next) begin
            mode_reg <= ST_NIGHT;
          end
        end
        ST_NIGHT: begin
          if (!night_next) begin
            mode_reg <= ST_DAY;
          end
        end
      endcase
    end
  end

  // All alarms in one process; a healthy photocell changes at least once a day
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pec_sec_reg <= 32'h0;
      pec_prev_reg <= 1'b0;
      alarm_reg <= '0;
      night_prev_reg <= 1'b0;
    end else begin
      pec_prev_reg <= photocell_dark;
      night_prev_reg <= (mode_reg == ST_NIGHT);
      alarm_reg.red <= (mode_reg == ST_NIGHT) && (miss_reg == RED_MISS_LIMIT); // RULE_06
      alarm_reg.night_err <= (mode_reg == ST_NIGHT) && (miss_reg != 2'h0); // RULE_07
      alarm_reg.marker <= marker_sense_fail; // RULE_08
      if (photocell_dark != pec_prev_reg) begin
        pec_sec_reg <= 32'h0;
        alarm_reg.pec <= 1'b0;
      end else if (tick && !alarm_reg.pec) begin
        if (pec_sec_reg == PHOTOCELL_ALARM_LAMP_LEN_S - 1) begin
          alarm_reg.pec <= 1'b1; // RULE_05
        end
        pec_sec_reg <= pec_sec_reg + 32'h1;
      end
    end
  end

  // Missed flashes: a fire with the previous one still unconfirmed is a miss
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      miss_reg <= 2'h0;
      pending_reg <= 1'b0;
    end else if (mode_reg != ST_NIGHT || !night_prev_reg) begin
      miss_reg <= 2'h0; // RULE_17
      pending_reg <= fire;
    end else if (flash_detect) begin
      miss_reg <= 2'h0; // RULE_17
      pending_reg <= fire;
    end else if (fire) begin
      pending_reg <= 1'b1;
      if (pending_reg && miss_reg != RED_MISS_LIMIT) begin
        miss_reg <= miss_reg + 2'h1;
      end
    end
  end

  // Lamps and field outputs, all registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strobe_fire <= 1'b0;
      strobe_low_intensity <= 1'b0;
      marker_relay <= 1'b0;
      marker_on_lamp <= 1'b0;
      day_mode_lamp <= 1'b1;
      night_mode_lamp <= 1'b0;
      sync_lamp <= 1'b0;
      trigger_supply_lamp <= 1'b0;
      interconnect_sync_line <= 1'b0;
      interconnect_mode_line <= 1'b0;
    end else begin
      strobe_fire <= fire; // RULE_10
      strobe_low_intensity <= (mode_reg == ST_NIGHT); // RULE_11
      marker_relay <= (mode_reg == ST_NIGHT) && ctrl_reg[CTRL_MARKERS_BIT]; // RULE_02
      marker_on_lamp <= (mode_reg == ST_NIGHT) && ctrl_reg[CTRL_MARKERS_BIT]; // RULE_02
      day_mode_lamp <= (mode_reg == ST_DAY); // RULE_01
      night_mode_lamp <= (mode_reg == ST_NIGHT); // RULE_01
      sync_lamp <= (sync_pulse_reg != 32'h0); // RULE_03
      trigger_supply_lamp <= trigger_voltage_present; // RULE_09
      // Idle lines read as day at a slave, which is its safe fallback
      interconnect_sync_line <= ctrl_reg[CTRL_MASTER_BIT] && (sync_pulse_reg != 32'h0); // RULE_14
      interconnect_mode_line <= ctrl_reg[CTRL_MASTER_BIT] && (mode_reg == ST_NIGHT); // RULE_14 RULE_16
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_lamp_a <= 1'b0;
    end else if (flash_detect) begin
      flash_lamp_a <= !flash_lamp_a; // RULE_04
    end
  end

  assign photocell_alarm_lamp = alarm_reg.pec; // RULE_05
  assign red_alarm_lamp = alarm_reg.red;
  assign night_intensity_error_lamp = alarm_reg.night_err;
  assign marker_failure_lamp = alarm_reg.marker;

  // Interrupts on alarm rises and mode changes; a new event beats a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_prev_reg <= '0;
    end else begin
      alarm_prev_reg <= alarm_reg;
    end
  end
  assign int_events = {(mode_reg == ST_NIGHT) != night_prev_reg, alarm_reg & ~alarm_prev_reg};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat_reg <= '0;
    end else if (apb_done && pwrite && paddr == INT_STAT_ADDR) begin
      int_stat_reg <= (int_stat_reg & ~pwdata[INT_WIDTH-1:0]) | int_events;
    end else begin
      int_stat_reg <= int_stat_reg | int_events;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_stat_reg & int_mask_reg);
    end
  end

  // APB slave: one wait state so read data leaves a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= apb_access && !pready;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      if (apb_access && !pready) begin
        unique case (paddr)
          CTRL_ADDR: prdata <= {30'h0, ctrl_reg};
          STATUS_ADDR: begin
            prdata[STAT_NIGHT_BIT] <= (mode_reg == ST_NIGHT);
            prdata[STAT_OVERRIDE_BIT] <= override_active;
            prdata[STAT_OVR_DONE_BIT] <= ovr_done_reg;
            prdata[STAT_TRIGGER_BIT] <= trigger_supply_lamp;
            prdata[STAT_ALARM_LSB +: 4] <= alarm_reg;
            prdata[STAT_MISS_LSB +: 2] <= miss_reg;
          end
          INT_STAT_ADDR: prdata <= {27'h0, int_stat_reg};
          INT_MASK_ADDR: prdata <= {27'h0, int_mask_reg};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= CTRL_RESET;
      int_mask_reg <= INT_MASK_RESET;
    end else if (apb_done && pwrite) begin
      if (paddr == CTRL_ADDR) begin
        ctrl_reg <= pwdata[1:0];
      end
      if (paddr == INT_MASK_ADDR) begin
        int_mask_reg <= pwdata[INT_WIDTH-1:0];
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_forced_hold;
    sw_forced(intensity_select_switch) && $stable(intensity_select_switch);
  endsequence

  a_day_night_lamps: assert property ( // RULE_01
    day_mode_lamp != night_mode_lamp && night_mode_lamp == $past(mode_reg == ST_NIGHT))
    else $error("day and night lamps disagree with mode");
  a_marker_gate: assert property ( // RULE_02
    marker_on_lamp |-> $past(mode_reg == ST_NIGHT && ctrl_reg[CTRL_MARKERS_BIT]))
    else $error("marker lamp lit outside night with markers");
  a_sync_flick: assert property (sync_slot |=> ##1 sync_lamp) // RULE_03
    else $error("sync lamp did not flick");
  a_flash_toggle: assert property ( // RULE_04
    flash_detect |=> flash_lamp_a != $past(flash_lamp_a))
    else $error("flash_lamp_a lamp did not toggle");
  // One cycle only: a drop to day in the next cycle clears the alarm again
  a_red_after_three: assert property ( // RULE_06
    (mode_reg == ST_NIGHT && miss_reg == RED_MISS_LIMIT) |=> red_alarm_lamp)
    else $error("red alarm missing after three misses");
  a_night_err_level: assert property ( // RULE_07
    night_intensity_error_lamp |-> $past(mode_reg == ST_NIGHT && miss_reg != 2'h0))
    else $error("night error without missed flash");
  a_marker_alarm: assert property (marker_sense_fail |=> marker_failure_lamp) // RULE_08
    else $error("marker alarm did not follow sense");
  a_trigger_lamp: assert property ( // RULE_09
    trigger_supply_lamp == $past(trigger_voltage_present))
    else $error("trigger lamp does not follow input");
  a_no_day_fire: assert property ( // RULE_10
    strobe_fire |-> night_mode_lamp && strobe_low_intensity)
    else $error("strobe fired in day or at wrong intensity");
  // The timer may expire at the sampled edge, so only the next mode is bound
  a_forced_night: assert property ( // RULE_12
    (s_forced_hold and intensity_select_switch == SW_NIGHT && !ovr_done_reg) |=>
      mode_reg == ST_NIGHT)
    else $error("forced night not applied");
  a_override_ends: assert property ( // RULE_13
    (ovr_done_reg && $stable(intensity_select_switch) && pec_ready_reg && !photocell_dark) |=>
      mode_reg == ST_DAY)
    else $error("automatic control not resumed");
  a_pec_startup: assert property ( // RULE_15
    !pec_ready_reg && !override_active |=> mode_reg == ST_DAY)
    else $error("photocell acted before startup delay");
  a_miss_clear: assert property ( // RULE_17
    (flash_detect && mode_reg == ST_NIGHT) |=> miss_reg == 2'h0)
    else $error("missed count not cleared by flash");
  a_irq_level: assert property (irq == $past(|(int_stat_reg & int_mask_reg)))
    else $error("interrupt output wrong");

endmodule

// *** core/bmac_pkg.sv ***
// Package for the beacon mode and alarm controller: map, fields, timing
package bmac_pkg;

  // Clock rate and the one-second tick derived from it
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned TICK_S = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ * TICK_S;

  // Timing in seconds, sync pulse in milliseconds, as documented or chosen
  localparam int unsigned SYNC_PERIOD_S = 6;
  localparam int unsigned OVERRIDE_HOURS = 8;
  localparam int unsigned OVERRIDE_S = OVERRIDE_HOURS * 3600;
  localparam int unsigned PEC_STARTUP_S = 60;
  localparam int unsigned FLASH_PERIOD_S = 3;
  localparam int unsigned PHOTOCELL_ALARM_LAMP_S = 86400;
  localparam int unsigned SYNC_PULSE_MS = 100;
  localparam int unsigned SYNC_PULSE_CYCLES = (CLK_HZ / 1000) * SYNC_PULSE_MS;
  localparam logic [1:0] RED_MISS_LIMIT = 2'h3;

  // APB register byte addresses
  localparam logic [11:0] CTRL_ADDR = 12'h000;
  localparam logic [11:0] STATUS_ADDR = 12'h004;
  localparam logic [11:0] INT_STAT_ADDR = 12'h008;
  localparam logic [11:0] INT_MASK_ADDR = 12'h00c;

  // Control register fields and reset value
  localparam int CTRL_MASTER_BIT = 0;
  localparam int CTRL_MARKERS_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // Status register fields
  localparam int STAT_NIGHT_BIT = 0;
  localparam int STAT_OVERRIDE_BIT = 1;
  localparam int STAT_OVR_DONE_BIT = 2;
  localparam int STAT_TRIGGER_BIT = 3;
  localparam int STAT_ALARM_LSB = 4;
  localparam int STAT_MISS_LSB = 8;

  // Interrupt status and mask layout
  localparam int INT_WIDTH = 5;
  localparam int INT_MODE_BIT = 4;
  localparam logic [INT_WIDTH-1:0] INT_MASK_RESET = 5'h00;

  // Intensity select switch encoding
  localparam logic [1:0] SW_AUTO = 2'h0;
  localparam logic [1:0] SW_DAY = 2'h1;
  localparam logic [1:0] SW_NIGHT = 2'h2;

  typedef enum logic [1:0] {
    ST_DAY = 2'b01,
    ST_NIGHT = 2'b10
  } bmac_mode_t;

  typedef struct packed {
    logic marker;
    logic pec;
    logic night_err;
    logic red;
  } bmac_alarm_t;

endpackage

// *** test/bmac_slave_model.sv ***
// Behavioural slave beacon unit that follows the master over the interconnect
`timescale 1ns/1ps

module bmac_slave_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic link_connected,
  input wire logic interconnect_mode_line,
  output logic slave_night
);
  // A cut line reads as the day level, so a lost master never leaves a slave in night mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slave_night <= 1'b0;
    end else begin
      slave_night <= link_connected & interconnect_mode_line;
    end
  end
endmodule

// *** test/tb_top.sv ***
// Self-checking testbench for the beacon mode and alarm controller
`timescale 1ns/1ps

module tb_top;
  import bmac_pkg::*;

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [1:0] intensity_select_switch = SW_AUTO;
  logic photocell_dark = 1'b1;
  logic flash_detect = 1'b0;
  logic marker_sense_fail = 1'b0;
  logic trigger_voltage_present = 1'b0;
  logic link_connected = 1'b1;
  logic [31:0] prdata;
  logic pready, pslverr, strobe_fire, strobe_low_intensity, marker_relay;
  logic day_mode_lamp, night_mode_lamp, marker_on_lamp, sync_lamp, flash_lamp_a;
  logic photocell_alarm_lamp, red_alarm_lamp, night_intensity_error_lamp;
  logic marker_failure_lamp, trigger_supply_lamp, interconnect_sync_line;
  logic interconnect_mode_line, irq, slave_night;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;

  // Shortened counts: tick 10 cycles, override 5 ticks, photocell alarm 20 ticks
  bmac_ctrl #(.TICK_LEN(10), .OVERRIDE_LEN_S(5), .PHOTOCELL_ALARM_LAMP_LEN_S(20), .SYNC_PULSE_LEN(3))
  bmac_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .intensity_select_switch(intensity_select_switch),
    .photocell_dark(photocell_dark), .flash_detect(flash_detect),
    .marker_sense_fail(marker_sense_fail), .trigger_voltage_present(trigger_voltage_present),
    .strobe_fire(strobe_fire), .strobe_low_intensity(strobe_low_intensity),
    .marker_relay(marker_relay), .day_mode_lamp(day_mode_lamp),
    .night_mode_lamp(night_mode_lamp), .marker_on_lamp(marker_on_lamp),
    .sync_lamp(sync_lamp), .flash_lamp_a(flash_lamp_a),
    .photocell_alarm_lamp(photocell_alarm_lamp), .red_alarm_lamp(red_alarm_lamp),
    .night_intensity_error_lamp(night_intensity_error_lamp),
    .marker_failure_lamp(marker_failure_lamp), .trigger_supply_lamp(trigger_supply_lamp),
    .interconnect_sync_line(interconnect_sync_line),
    .interconnect_mode_line(interconnect_mode_line), .irq(irq));

  bmac_slave_model bmac_slave_model_i (.pclk(pclk), .presetn(presetn),
    .link_connected(link_connected), .interconnect_mode_line(interconnect_mode_line),
    .slave_night(slave_night));

  always #12.5 pclk = ~pclk;

  task automatic summarize();
    if (fail_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // The whole sequence needs about 1200 cycles
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 10000) begin
      fail_count++;
      summarize();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // Ends when pready is seen high; only the bench timeout ends a wait where it never rises
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    check("pready", pready, 1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  // Every window length used is a multiple of both periods, so alignment does not matter
  task automatic count_sync(input int n, output int s, output int l, output int f);
    s = 0;
    l = 0;
    f = 0;
    repeat (n) begin
      @(posedge pclk);
      s += int'(sync_lamp === 1'b1);
      l += int'(interconnect_sync_line === 1'b1);
      f += int'(strobe_fire === 1'b1);
    end
  endtask

  initial begin : main
    logic [31:0] r;
    logic e;
    logic lamp;
    int s, l, f;
    cyc(6);
    presetn <= 1'b1;
    cyc(1);
    check("day_lamp", day_mode_lamp, 1);
    check("night_lamp", night_mode_lamp, 0);
    apb(1'b0, CTRL_ADDR, 32'h0, r, e);
    check("ctrl_reset", r, 32'h0);
    apb(1'b0, INT_MASK_ADDR, 32'h0, r, e);
    check("mask_reset", r, 32'h0);
    apb(1'b0, 12'h010, 32'h0, r, e);
    check("unmapped_err", e, 1);
    check("unmapped_data", r, 32'h0);
    wr(CTRL_ADDR, 32'h3);
    apb(1'b0, CTRL_ADDR, 32'h0, r, e);
    check("ctrl", r, 32'h3);
    trigger_voltage_present <= 1'b1;
    marker_sense_fail <= 1'b1;
    cyc(2);
    check("trig_lamp_on", trigger_supply_lamp, 1);
    check("mkr_alarm_on", marker_failure_lamp, 1);
    trigger_voltage_present <= 1'b0;
    marker_sense_fail <= 1'b0;
    cyc(2);
    check("trig_lamp_off", trigger_supply_lamp, 0);
    check("mkr_alarm_off", marker_failure_lamp, 0);
    count_sync(300, s, l, f);
    check("day_sync", s, 15);
    check("day_link_sync", l, 15);
    check("day_fires", f, 0);
    check("startup_day", day_mode_lamp, 1);
    check("photocell_alarm_lamp", photocell_alarm_lamp, 1);
    check("day_markers", marker_relay, 0);
    repeat (400) if (night_mode_lamp !== 1'b1) @(posedge pclk);
    cyc(1);
    check("night_lamp", night_mode_lamp, 1);
    check("day_lamp_off", day_mode_lamp, 0);
    check("low_int", strobe_low_intensity, 1);
    check("mkr_relay", marker_relay, 1);
    check("mkr_lamp", marker_on_lamp, 1);
    check("mode_line", interconnect_mode_line, 1);
    check("slave_night", slave_night, 1);
    repeat (300) if (red_alarm_lamp !== 1'b1) @(posedge pclk);
    check("red_alarm", red_alarm_lamp, 1);
    check("night_err", night_intensity_error_lamp, 1);
    check("irq_masked", irq, 0);
    wr(INT_MASK_ADDR, 32'h1);
    cyc(2);
    check("irq_on", irq, 1);
    apb(1'b0, INT_STAT_ADDR, 32'h0, r, e);
    check("int_stat", r, 32'h1f);
    apb(1'b0, STATUS_ADDR, 32'h0, r, e);
    check("status", r, 32'h371);
    wr(INT_STAT_ADDR, 32'h1);
    cyc(2);
    check("irq_clear", irq, 0);
    apb(1'b0, INT_STAT_ADDR, 32'h0, r, e);
    check("int_stat_w1c", r, 32'h1e);
    repeat (40) if (strobe_fire !== 1'b1) @(posedge pclk);
    lamp = flash_lamp_a;
    flash_detect <= 1'b1;
    cyc(1);
    flash_detect <= 1'b0;
    cyc(2);
    check("flash_lamp_a_lamp", flash_lamp_a, 32'(!lamp));
    check("miss_clr_err", night_intensity_error_lamp, 0);
    check("miss_clr_red", red_alarm_lamp, 0);
    count_sync(300, s, l, f);
    check("night_sync", s, 15);
    check("night_link_sync", l, 15);
    check("night_fires", f, 10);
    link_connected <= 1'b0;
    cyc(2);
    check("slave_cut", slave_night, 0);
    link_connected <= 1'b1;
    photocell_dark <= 1'b0;
    cyc(3);
    check("photocell_alarm_lamp_clr", photocell_alarm_lamp, 0);
    check("auto_day", day_mode_lamp, 1);
    check("day_low_int", strobe_low_intensity, 0);
    check("day_mkr_off", marker_on_lamp, 0);
    check("day_mode_line", interconnect_mode_line, 0);
    intensity_select_switch <= SW_DAY;
    cyc(35);
    check("forced_day", day_mode_lamp, 1);
    intensity_select_switch <= SW_NIGHT;
    cyc(35);
    check("restart_night", night_mode_lamp, 1);
    repeat (80) if (day_mode_lamp !== 1'b1) @(posedge pclk);
    check("expired_day", day_mode_lamp, 1);
    apb(1'b0, STATUS_ADDR, 32'h0, r, e);
    check("expired_status", r, 32'h4);
    intensity_select_switch <= SW_AUTO;
    cyc(3);
    apb(1'b0, STATUS_ADDR, 32'h0, r, e);
    check("auto_status", r, 32'h0);
    intensity_select_switch <= SW_NIGHT;
    cyc(35);
    check("cleared_night", night_mode_lamp, 1);
    summarize();
  end
endmodule
